//--- design/occ_defs.svh
// Constants for the oscillator control register block: offsets, fields, resets, keys.
// Assumes a 32-bit AXI4-Lite register bus; included by bare name.
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OCC_ADDR_W 4
`define OCC_OFS_CTRL 4'h0
`define OCC_OFS_KEY 4'h4

// ----------------------------------------
// Field positions in the control word
// ----------------------------------------
`define OCC_PLL_POST_DIVIDER_MSB 29
`define OCC_PLL_POST_DIVIDER_LSB 27
`define OCC_FAST_RC_DIVIDER_MSB 26
`define OCC_FAST_RC_DIVIDER_LSB 24
`define OCC_SECRDY_BIT 22
`define OCC_DIVRDY_BIT 21
`define OCC_PERIPH_CLOCK_DIVISOR_MSB 20
`define OCC_PERIPH_CLOCK_DIVISOR_LSB 19

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define OCC_FAST_RC_DIVIDER_RST 3'h1
`define OCC_DIV_CODE_MAX 3'h7
`define OCC_SHIFT_MAX 4'h8
`define OCC_KEY_FIRST 32'h5a5a0f0f
`define OCC_KEY_SECOND 32'ha5a5f0f0
`define OCC_RESP_OKAY 2'h0
`define OCC_RESP_SLVERR 2'h2
`define OCC_NUM_DIV 3
`define OCC_DIV_PLL 0
`define OCC_DIV_FRC 1
`define OCC_DIV_PB 2

`endif

//--- design/occ_pkg.sv
// Types shared by the oscillator control register block.
// Assumes occ_defs.svh is available on the include path.
package occ_pkg;

	// ----------------------------------------
	// Configuration straps and live fields
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] pllPostDivider;
		logic [1:0] periphClockDivisor;
	} occ_cfg_t;

	typedef struct packed {
		logic [2:0] pllPostDivider;
		logic [2:0] fastRcDivider;
		logic [1:0] periphClockDivisor;
	} occ_ctrl_t;

	// ----------------------------------------
	// Unlock sequence states, Gray along the path
	// ----------------------------------------
	typedef enum logic [1:0] {
		OCC_LOCKED = 2'h0,
		OCC_KEY1_SEEN = 2'h1,
		OCC_OPEN = 2'h3
	} occ_lock_t;

endpackage

//--- design/occ_tick_divider.sv
// Tick divider: passes one of every 2**shiftAmt input ticks as a one-cycle pulse.
// Assumes tickIn is a one-cycle enable in the clk domain and shiftAmt is at most 8.
`timescale 1ns/1ps
`default_nettype none
module occ_tick_divider (
	input wire logic clk,
	input wire logic srst,
	input wire logic tickIn,
	input wire logic [3:0] shiftAmt,
	output logic wrap,
	output logic tickOut
);
	logic [7:0] cnt_ff;
	logic [7:0] terminal;
	logic tickOut_ff;

	// ----------------------------------------
	// Count and wrap
	// ----------------------------------------
	assign terminal = 8'((9'h1 << shiftAmt) - 9'h1);
	assign wrap = tickIn && (cnt_ff >= terminal);
	assign tickOut = tickOut_ff;

	// Wrap on >= so a ratio shrunk mid-count does not run through 256 ticks
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff <= 8'h0;
		end else if (wrap) begin
			cnt_ff <= 8'h0;
		end else if (tickIn) begin
			cnt_ff <= cnt_ff + 8'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tickOut_ff <= 1'b0;
		end else begin
			tickOut_ff <= wrap;
		end
	end
endmodule
`default_nettype wire

//--- design/occ_oscillator_control.sv
// Oscillator control register with key unlock, behind an AXI4-Lite slave.
// Assumes one 100 MHz clock; PLL and fast RC clocks arrive as one-cycle tick enables.
//
// Notes on behaviour
// - PLL post-divider codes divide 1..64, then 256
// - Fast RC divider same ratios, resets to two
// - Secondary oscillator ready reads stable state only
// - Divisor ready low blocks periph divisor writes
// - Periph divisor divides system clock 1,2,4,8
// - Control writes accepted only after unlock
// - Reset loads straps into config-derived fields
// - Bits 31:30 and 23 read zero
`timescale 1ns/1ps
`default_nettype none
`include "occ_defs.svh"
module occ_oscillator_control (
	input wire logic clk,
	input wire logic srst,
	input wire occ_pkg::occ_cfg_t cfgStraps,
	input wire logic secOscStable,
	input wire logic pllTickIn,
	input wire logic frcTickIn,
	input wire logic [`OCC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`OCC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output occ_pkg::occ_ctrl_t ctrlOut,
	output logic pllPostTick,
	output logic frcTick,
	output logic peripheralBusTick
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	occ_pkg::occ_ctrl_t ctrl_ff;
	occ_pkg::occ_lock_t lock_ff;
	logic [1:0] pendingDiv_ff;
	logic pendingValid_ff;
	logic secOscReady_ff;
	logic [`OCC_ADDR_W-1:0] awAddr_ff;
	logic awHave_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic wHave_ff;
	logic bValid_ff;
	logic [1:0] bResp_ff;
	logic rValid_ff;
	logic [31:0] rData_ff;
	logic [1:0] rResp_ff;
	logic doWrite;
	logic writeCtrl;
	logic writeKey;
	logic [31:0] byteMask;
	logic [31:0] ctrlWord;
	logic [31:0] nxt_ctrlWord;
	logic divisorReady;
	logic [`OCC_NUM_DIV-1:0] divTickIn;
	logic [`OCC_NUM_DIV-1:0] divWrap;
	logic [`OCC_NUM_DIV-1:0] divTickOut;
	logic [3:0] divShift [`OCC_NUM_DIV];

	// Codes 0..6 are plain powers of two; the top code jumps to 256
	function automatic logic [3:0] occShiftOf(input logic [2:0] code);
		occShiftOf = (code == `OCC_DIV_CODE_MAX) ? `OCC_SHIFT_MAX : {1'b0, code};
	endfunction

	// ----------------------------------------
	// Register word view
	// ----------------------------------------
	always_comb begin
		ctrlWord = 32'h0;
		ctrlWord[`OCC_PLL_POST_DIVIDER_MSB:`OCC_PLL_POST_DIVIDER_LSB] = ctrl_ff.pllPostDivider;
		ctrlWord[`OCC_FAST_RC_DIVIDER_MSB:`OCC_FAST_RC_DIVIDER_LSB] = ctrl_ff.fastRcDivider;
		ctrlWord[`OCC_SECRDY_BIT] = secOscReady_ff;
		ctrlWord[`OCC_DIVRDY_BIT] = divisorReady;
		ctrlWord[`OCC_PERIPH_CLOCK_DIVISOR_MSB:`OCC_PERIPH_CLOCK_DIVISOR_LSB] = ctrl_ff.periphClockDivisor;
	end

	assign divisorReady = !pendingValid_ff;
	assign ctrlOut = ctrl_ff;

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	assign s_axi_awready = !awHave_ff && !bValid_ff;
	assign s_axi_wready = !wHave_ff && !bValid_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_bresp = bResp_ff;
	assign doWrite = awHave_ff && wHave_ff && !bValid_ff;
	assign writeCtrl = doWrite && (awAddr_ff == `OCC_OFS_CTRL);
	assign writeKey = doWrite && (awAddr_ff == `OCC_OFS_KEY);

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_mask
			assign byteMask[gb*8 +: 8] = {8{wStrb_ff[gb]}};
		end
	endgenerate

	assign nxt_ctrlWord = (ctrlWord & ~byteMask) | (wData_ff & byteMask);

	always_ff @(posedge clk) begin
		if (srst) begin
			awHave_ff <= 1'b0;
			awAddr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHave_ff <= 1'b1;
			awAddr_ff <= s_axi_awaddr;
		end else if (doWrite) begin
			awHave_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wHave_ff <= 1'b0;
			wData_ff <= 32'h0;
			wStrb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHave_ff <= 1'b1;
			wData_ff <= s_axi_wdata;
			wStrb_ff <= s_axi_wstrb;
		end else if (doWrite) begin
			wHave_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bValid_ff <= 1'b0;
			bResp_ff <= `OCC_RESP_OKAY;
		end else if (doWrite) begin
			bValid_ff <= 1'b1;
			bResp_ff <= (writeCtrl || writeKey) ? `OCC_RESP_OKAY : `OCC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Unlock sequence
	// ----------------------------------------
	// Any other key word, or a control write, drops back to locked
	always_ff @(posedge clk) begin
		if (srst) begin
			lock_ff <= occ_pkg::OCC_LOCKED;
		end else if (writeKey) begin
			case (lock_ff)
				occ_pkg::OCC_LOCKED: begin
					lock_ff <= (wData_ff == `OCC_KEY_FIRST) ? occ_pkg::OCC_KEY1_SEEN
						: occ_pkg::OCC_LOCKED;
				end
				occ_pkg::OCC_KEY1_SEEN: begin
					lock_ff <= (wData_ff == `OCC_KEY_SECOND) ? occ_pkg::OCC_OPEN
						: occ_pkg::OCC_LOCKED;
				end
				default: begin
					lock_ff <= occ_pkg::OCC_LOCKED;
				end
			endcase
		end else if (writeCtrl) begin
			lock_ff <= occ_pkg::OCC_LOCKED;
		end
	end

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_ff.pllPostDivider <= cfgStraps.pllPostDivider;
			ctrl_ff.fastRcDivider <= `OCC_FAST_RC_DIVIDER_RST;
		end else if (writeCtrl && lock_ff == occ_pkg::OCC_OPEN) begin
			ctrl_ff.pllPostDivider <= nxt_ctrlWord[`OCC_PLL_POST_DIVIDER_MSB:`OCC_PLL_POST_DIVIDER_LSB];
			ctrl_ff.fastRcDivider <= nxt_ctrlWord[`OCC_FAST_RC_DIVIDER_MSB:`OCC_FAST_RC_DIVIDER_LSB];
		end
	end

	// A new divisor waits for the current period to end, so no short bus pulse appears
	always_ff @(posedge clk) begin
		if (srst) begin
			pendingValid_ff <= 1'b0;
			pendingDiv_ff <= 2'h0;
		end else if (writeCtrl && lock_ff == occ_pkg::OCC_OPEN && divisorReady
			&& nxt_ctrlWord[`OCC_PERIPH_CLOCK_DIVISOR_MSB:`OCC_PERIPH_CLOCK_DIVISOR_LSB] != ctrl_ff.periphClockDivisor) begin
			pendingValid_ff <= 1'b1;
			pendingDiv_ff <= nxt_ctrlWord[`OCC_PERIPH_CLOCK_DIVISOR_MSB:`OCC_PERIPH_CLOCK_DIVISOR_LSB];
		end else if (divWrap[`OCC_DIV_PB]) begin
			pendingValid_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_ff.periphClockDivisor <= cfgStraps.periphClockDivisor;
		end else if (pendingValid_ff && divWrap[`OCC_DIV_PB]) begin
			ctrl_ff.periphClockDivisor <= pendingDiv_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			secOscReady_ff <= 1'b0;
		end else begin
			secOscReady_ff <= secOscStable;
		end
	end

	// ----------------------------------------
	// Clock dividers as tick enables
	// ----------------------------------------
	assign divTickIn[`OCC_DIV_PLL] = pllTickIn;
	assign divTickIn[`OCC_DIV_FRC] = frcTickIn;
	assign divTickIn[`OCC_DIV_PB] = 1'b1;
	assign divShift[`OCC_DIV_PLL] = occShiftOf(ctrl_ff.pllPostDivider);
	assign divShift[`OCC_DIV_FRC] = occShiftOf(ctrl_ff.fastRcDivider);
	assign divShift[`OCC_DIV_PB] = {2'b00, ctrl_ff.periphClockDivisor};

	genvar gd;
	generate
		for (gd = 0; gd < `OCC_NUM_DIV; gd++) begin : g_div
			occ_tick_divider u_div (
				.clk(clk),
				.srst(srst),
				.tickIn(divTickIn[gd]),
				.shiftAmt(divShift[gd]),
				.wrap(divWrap[gd]),
				.tickOut(divTickOut[gd])
			);
		end
	endgenerate

	assign pllPostTick = divTickOut[`OCC_DIV_PLL];
	assign frcTick = divTickOut[`OCC_DIV_FRC];
	assign peripheralBusTick = divTickOut[`OCC_DIV_PB];

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	assign s_axi_arready = !rValid_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_rresp = rResp_ff;

	// The key register reads back zero so the keys never leak to software
	always_ff @(posedge clk) begin
		if (srst) begin
			rValid_ff <= 1'b0;
			rData_ff <= 32'h0;
			rResp_ff <= `OCC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rValid_ff <= 1'b1;
			case (s_axi_araddr)
				`OCC_OFS_CTRL: begin
					rData_ff <= ctrlWord;
					rResp_ff <= `OCC_RESP_OKAY;
				end
				`OCC_OFS_KEY: begin
					rData_ff <= 32'h0;
					rResp_ff <= `OCC_RESP_OKAY;
				end
				default: begin
					rData_ff <= 32'h0;
					rResp_ff <= `OCC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rValid_ff <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- tb/occ_oscillator_control_assertions.sv
// Checker for the oscillator control block: bus answers, field loads, tick spacing.
// Assumes it is bound to occ_oscillator_control and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module occ_oscillator_control_assertions (
	input wire logic clk,
	input wire logic srst,
	input wire occ_pkg::occ_cfg_t cfgStraps,
	input wire logic pllTickIn,
	input wire logic frcTickIn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire occ_pkg::occ_ctrl_t ctrlOut,
	input wire logic pllPostTick,
	input wire logic frcTick,
	input wire logic peripheralBusTick
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ----
	// Properties
	// ----
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write not answered");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
	unused_zero_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:30] == 2'h0 && !s_axi_rdata[23])
		else $error("unused bits set");
	strap_load_a: assert property ($fell(srst) |->
		ctrlOut == {cfgStraps.pllPostDivider, 3'h1, cfgStraps.periphClockDivisor})
		else $error("reset fields wrong");
	field_guard_a: assert property (
		$changed(ctrlOut.fastRcDivider) || $changed(ctrlOut.pllPostDivider) |-> $rose(s_axi_bvalid))
		else $error("field changed without write");
	// Every PLL and fast RC output pulse must trace back to an input tick
	pll_tick_a: assert property (pllPostTick |-> $past(pllTickIn))
		else $error("pll tick without input");
	frc_tick_a: assert property (frcTick |-> $past(frcTickIn))
		else $error("fast rc tick without input");
	pb_slow_a: assert property (
		peripheralBusTick && ctrlOut.periphClockDivisor == 2'h3 |=> !peripheralBusTick [*7])
		else $error("bus tick too early");
	divisor_wrap_a: assert property (
		$changed(ctrlOut.periphClockDivisor) |-> peripheralBusTick)
		else $error("divisor changed off a wrap");
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property (peripheralBusTick && ctrlOut.periphClockDivisor == 2'h3);
	cover property ($changed(ctrlOut.periphClockDivisor));
endmodule
bind occ_oscillator_control occ_oscillator_control_assertions u_occ_oscillator_control_assertions (
	.clk(clk),
	.srst(srst),
	.cfgStraps(cfgStraps),
	.pllTickIn(pllTickIn),
	.frcTickIn(frcTickIn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.ctrlOut(ctrlOut),
	.pllPostTick(pllPostTick),
	.frcTick(frcTick),
	.peripheralBusTick(peripheralBusTick)
);
`default_nettype wire

//--- tb/test_oscillator_control_register.sv
// Self-checking bench for the oscillator control block over AXI4-Lite.
// Assumes package, design and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "occ_defs.svh"
module test_oscillator_control_register;
	localparam logic [3:0] CT = `OCC_OFS_CTRL;
	localparam logic [3:0] KY = `OCC_OFS_KEY;
	localparam logic [1:0] OK = `OCC_RESP_OKAY;
	localparam logic [1:0] SE = `OCC_RESP_SLVERR;
	logic clk = 1'h0, srst = 1'h1, secOscStable = 1'h0, pllTickIn = 1'h1, frcTickIn = 1'h0;
	occ_pkg::occ_cfg_t cfgStraps = 5'h15;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	occ_pkg::occ_ctrl_t ctrlOut;
	logic pllPostTick, frcTick, peripheralBusTick;
	wire logic [2:0] tk = {peripheralBusTick, frcTick, pllPostTick};
	int num_errors = 0, checked = 0, n;
	logic [3:0] c;

	occ_oscillator_control u_occ_oscillator_control (
		.clk(clk),
		.srst(srst),
		.cfgStraps(cfgStraps),
		.secOscStable(secOscStable),
		.pllTickIn(pllTickIn),
		.frcTickIn(frcTickIn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.ctrlOut(ctrlOut),
		.pllPostTick(pllPostTick),
		.frcTick(frcTick),
		.peripheralBusTick(peripheralBusTick)
	);

	initial begin
		forever #5 clk = ~clk;
	end
	// PLL and fast RC tick on alternate cycles, so both gaps double
	always @(posedge clk) begin
		frcTickIn <= ~frcTickIn;
		pllTickIn <= frcTickIn;
	end
	// ----
	// Helpers
	// ----
	function logic [31:0] cw(logic [2:0] p, logic [2:0] f, logic s, logic r, logic [1:0] d);
		return {2'h0, p, f, 1'h0, s, r, d, 19'h0};
	endfunction
	function int rat(logic [2:0] k);
		return k == 3'h7 ? 256 : 1 << k;
	endfunction
	task stop_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task tmo;
		chk("wait", 32'h0, 32'h1);
		stop_test;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) break;
		end
		if (k == 50) tmo;
		s_axi_bready <= 1'h0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		int k;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) break;
		end
		if (k == 50) tmo;
		s_axi_rready <= 1'h0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask
	task unlock;
		wr(KY, `OCC_KEY_FIRST, OK);
		wr(KY, `OCC_KEY_SECOND, OK);
	endtask
	// Cycles from one output pulse to the next, sampled off the edge
	task gap(input int i, output int g);
		int k;
		k = 0;
		do begin @(negedge clk); k++; end while (tk[i] !== 1'h1 && k < 600);
		if (k == 600) tmo;
		g = 0;
		do begin @(negedge clk); g++; end while (tk[i] !== 1'h1 && g < 600);
	endtask
	// ----
	// Tests
	// ----
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		rd(CT, cw(3'h5, 3'h1, 1'h0, 1'h1, 2'h1), OK);
		wr(CT, 32'hffffffff, OK);
		rd(CT, cw(3'h5, 3'h1, 1'h0, 1'h1, 2'h1), OK);
		$display("done reset and lock");
		unlock;
		wr(CT, 32'hffffffff, OK);
		repeat (20) @(posedge clk);
		rd(CT, cw(3'h7, 3'h7, 1'h0, 1'h1, 2'h3), OK);
		wr(CT, 32'h0, OK);
		rd(CT, cw(3'h7, 3'h7, 1'h0, 1'h1, 2'h3), OK);
		wr(KY, `OCC_KEY_FIRST, OK);
		wr(KY, 32'h0, OK);
		wr(KY, `OCC_KEY_SECOND, OK);
		wr(CT, 32'h0, OK);
		rd(CT, cw(3'h7, 3'h7, 1'h0, 1'h1, 2'h3), OK);
		wr(4'h8, 32'h0, SE);
		rd(4'h8, 32'h0, SE);
		$display("done unlock and unmapped");
		secOscStable <= 1'h1;
		for (c = 4'h0; c < 4'h8; c++) begin
			unlock;
			wr(CT, cw(c[2:0], c[2:0], 1'h0, 1'h0, c[1:0]), OK);
			repeat (20) @(posedge clk);
			rd(CT, cw(c[2:0], c[2:0], 1'h1, 1'h1, c[1:0]), OK);
			chk("ctrlOut", {24'h0, c[2:0], c[2:0], c[1:0]}, {24'h0, ctrlOut});
			gap(0, n);
			chk("pll gap", 2 * rat(c[2:0]), n);
			gap(1, n);
			chk("frc gap", 2 * rat(c[2:0]), n);
			gap(2, n);
			chk("bus gap", 1 << c[1:0], n);
		end
		$display("done divider ratios");
		// Align to a bus tick so the read lands before the slow wrap
		unlock;
		gap(2, n);
		wr(CT, cw(3'h7, 3'h7, 1'h0, 1'h0, 2'h0), OK);
		rd(CT, cw(3'h7, 3'h7, 1'h1, 1'h0, 2'h3), OK);
		repeat (20) @(posedge clk);
		rd(CT, cw(3'h7, 3'h7, 1'h1, 1'h1, 2'h0), OK);
		$display("done divisor ready");
		// Only the top byte is strobed, so the divisor byte must keep its value
		unlock;
		s_axi_wstrb <= 4'h8;
		wr(CT, cw(3'h2, 3'h3, 1'h0, 1'h0, 2'h3), OK);
		s_axi_wstrb <= 4'hf;
		rd(CT, cw(3'h2, 3'h3, 1'h1, 1'h1, 2'h0), OK);
		$display("done byte strobes");
		stop_test;
	end
endmodule
`default_nettype wire
